/* logic/lcj_pkg.sv */
// package: constants for the long call, long jump and byte move executor
package lcj_pkg;
  localparam logic [7:0] ESC_PREFIX    = 8'hA5;
  localparam logic [7:0] OP_CALL_IND   = 8'h99;
  localparam logic [7:0] OP_JMP_ABS    = 8'h02;
  localparam logic [7:0] OP_JMP_IND    = 8'h89;
  localparam logic [7:0] OP_MOV_D8_RN  = 8'h88;
  localparam logic [7:0] OP_MOV_RN_D8  = 8'hA8;
  localparam logic [7:0] OP_MOV_D8_D8  = 8'h85;
  localparam logic [7:0] OP_MOV_D8_A   = 8'hF5;
  localparam logic [7:0] OP_MOV_A_D8   = 8'hE5;
  localparam logic [4:0] MOVE_COMBOS   = 5'h18;
  localparam logic [15:0] CALL_ADVANCE = 16'h0003;
  localparam logic [7:0] SP_STEP       = 8'h01;
  localparam logic [7:0] PORT_LO       = 8'h80;
  localparam logic [7:0] PORT_STRIDE   = 8'h10;
  localparam logic [1:0] PORT_COUNT_M1 = 2'h3;
  localparam logic [3:0] PORT_EXTRA    = 4'h1;
  localparam logic [3:0] BASE_STATES   = 4'h2;
  typedef enum logic [2:0] {
    LCJ_IDLE  = 3'b000,
    LCJ_ESC   = 3'b001,
    LCJ_PUSHL = 3'b010,
    LCJ_PUSHH = 3'b011,
    LCJ_LOADP = 3'b100,
    LCJ_MOVE  = 3'b101,
    LCJ_WAIT  = 3'b110
  } lcj_state_t;
endpackage : lcj_pkg

/* logic/lcj_port_hit.sv */
// module: flags a direct address that falls on an I/O port register
`timescale 1ns/100ps
module lcj_port_hit (
  // address
  input  wire logic [7:0] addr,
  // result
  output logic            hit
);
  import lcj_pkg::*;
  logic [3:0] hits;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_port
      assign hits[g] = (addr == 8'(PORT_LO + 8'(g) * PORT_STRIDE));
    end
  endgenerate
  assign hit = |hits;
endmodule : lcj_port_hit

/* logic/lcj_exec.sv */
// module: executor for long call, long jump and byte move instructions
`timescale 1ns/100ps
module lcj_exec (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // instruction stream
  input  wire logic        instr_valid,
  input  wire logic [7:0]  instr_byte,
  input  wire logic [7:0]  opnd_a,
  input  wire logic [7:0]  opnd_b,
  input  wire logic        source_mode,
  // core state
  input  wire logic [15:0] pc_in,
  input  wire logic [7:0]  stack_pointer_in,
  input  wire logic [15:0] word_register_data,
  input  wire logic [15:0] mem_word,
  input  wire logic [7:0]  src_data,
  // memory and register writes, and the read address
  output logic             wr_en,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_data,
  output logic [15:0]      rd_addr,
  // results
  output logic             pc_load,
  output logic [15:0]      pc_out,
  output logic [7:0]       stack_pointer,
  output logic             busy,
  output logic             done,
  output logic             illegal
);
  import lcj_pkg::*;

  // sequencer and captured operands
  lcj_state_t  state_ff;
  lcj_state_t  nxt_state;
  logic [15:0] ret_ff;
  logic [7:0]  dst_ff;
  logic [3:0]  wait_ff;
  logic        esc_ff;
  // output registers
  logic        wr_en_ff;
  logic        pc_load_ff;
  logic        done_ff;
  logic        ill_ff;
  logic        busy_ff;
  logic [15:0] wr_addr_ff;
  logic [15:0] pc_ff;
  logic [15:0] rd_addr_ff;
  logic [7:0]  wr_data_ff;
  logic [7:0]  sp_ff;

  // opcode decode
  wire logic [7:0] cur_op   = instr_byte;
  wire logic is_call_ind    = cur_op == OP_CALL_IND;
  wire logic is_jmp_abs     = cur_op == OP_JMP_ABS;
  wire logic is_jmp_ind     = cur_op == OP_JMP_IND;
  wire logic is_reg_move    = (cur_op[7:3] == OP_MOV_D8_RN[7:3]) ||
                              (cur_op[7:3] == OP_MOV_RN_D8[7:3]);
  wire logic is_plain_move  = (cur_op == OP_MOV_D8_D8) || (cur_op == OP_MOV_D8_A) ||
                              (cur_op == OP_MOV_A_D8);
  wire logic is_prefix      = (cur_op == ESC_PREFIX) && (state_ff == LCJ_IDLE);

  // register-form moves sit in the escape page only in source mode
  wire logic need_esc       = is_reg_move && source_mode;
  wire logic esc_ok         = need_esc == esc_ff;
  // the indirect jump shares its byte with a register move; the page decides
  wire logic go_jmp_ind     = is_jmp_ind && (esc_ff != source_mode);
  wire logic is_move        = (is_reg_move && esc_ok) || is_plain_move;

  // address and count arithmetic
  wire logic [15:0] ret_adr  = 16'(pc_in + CALL_ADVANCE);
  wire logic [7:0]  sp_inc   = 8'(sp_ff + SP_STEP);
  wire logic [15:0] push_adr = {8'h00, sp_inc};
  wire logic [15:0] move_adr = {8'h00, dst_ff};
  wire logic [15:0] src_adr  = {8'h00, opnd_b};
  wire logic [15:0] jmp_adr  = {opnd_a, opnd_b};
  wire logic        port_hit;
  wire logic [3:0]  move_wait = port_hit ? 4'(BASE_STATES + PORT_EXTRA) : BASE_STATES;
  wire logic [3:0]  wait_dec  = 4'(wait_ff - 4'h1);
  wire logic        wait_last = (wait_ff <= 4'h1);
  wire logic        nxt_busy  = (nxt_state != LCJ_IDLE);

  lcj_port_hit u_port_hit (
    .addr (opnd_a),
    .hit  (port_hit)
  );

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      LCJ_IDLE, LCJ_ESC: begin
        // refused and unknown bytes fall back to idle
        if (instr_valid) begin
          if (is_prefix)
            nxt_state = LCJ_ESC;
          else if (is_call_ind)
            nxt_state = LCJ_PUSHL;
          else if (go_jmp_ind)
            nxt_state = LCJ_LOADP;
          else if (is_move)
            nxt_state = LCJ_MOVE;
          else
            nxt_state = LCJ_IDLE;
        end
      end
      LCJ_PUSHL: nxt_state = LCJ_PUSHH;
      LCJ_PUSHH: nxt_state = LCJ_LOADP;
      LCJ_LOADP: nxt_state = LCJ_IDLE;
      LCJ_MOVE:  nxt_state = LCJ_WAIT;
      LCJ_WAIT:  nxt_state = wait_last ? LCJ_IDLE : LCJ_WAIT;
      default:   nxt_state = LCJ_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff   <= LCJ_IDLE;
      ret_ff     <= 16'h0000;
      dst_ff     <= 8'h00;
      wait_ff    <= 4'h0;
      esc_ff     <= 1'b0;
      wr_en_ff   <= 1'b0;
      wr_addr_ff <= 16'h0000;
      wr_data_ff <= 8'h00;
      rd_addr_ff <= 16'h0000;
      pc_load_ff <= 1'b0;
      pc_ff      <= 16'h0000;
      sp_ff      <= 8'h00;
      done_ff    <= 1'b0;
      ill_ff     <= 1'b0;
      busy_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      busy_ff    <= nxt_busy;
      wr_en_ff   <= 1'b0;
      pc_load_ff <= 1'b0;
      done_ff    <= 1'b0;
      ill_ff     <= 1'b0;
      unique case (state_ff)
        LCJ_IDLE, LCJ_ESC: begin
          if (instr_valid) begin
            // an escape holds only for the byte that follows it
            esc_ff <= 1'b0;
            // pushes start from the pointer seen with the accepted byte
            sp_ff  <= stack_pointer_in;
            if (is_prefix) begin
              esc_ff <= 1'b1;
            end else if (is_call_ind) begin
              // return address is fixed before either push
              ret_ff     <= ret_adr;
              rd_addr_ff <= word_register_data;
            end else if (is_jmp_abs) begin
              pc_ff      <= jmp_adr;
              pc_load_ff <= 1'b1;
              done_ff    <= 1'b1;
            end else if (go_jmp_ind) begin
              // target is read a cycle later, once rd_addr has settled
              rd_addr_ff <= word_register_data;
            end else if (is_move) begin
              dst_ff     <= opnd_a;
              rd_addr_ff <= src_adr;
              wait_ff    <= move_wait;
            end else begin
              ill_ff     <= is_reg_move;
            end
          end
        end
        LCJ_PUSHL: begin
          // stack grows upward: step the pointer, then store
          sp_ff      <= sp_inc;
          wr_en_ff   <= 1'b1;
          wr_addr_ff <= push_adr;
          wr_data_ff <= ret_ff[7:0];
        end
        LCJ_PUSHH: begin
          sp_ff      <= sp_inc;
          wr_en_ff   <= 1'b1;
          wr_addr_ff <= push_adr;
          wr_data_ff <= ret_ff[15:8];
        end
        LCJ_LOADP: begin
          // shared by the call and the indirect jump
          pc_ff      <= mem_word;
          pc_load_ff <= 1'b1;
          done_ff    <= 1'b1;
        end
        LCJ_MOVE: begin
          // only the destination is written; flags are not touched here
          wr_en_ff   <= 1'b1;
          wr_addr_ff <= move_adr;
          wr_data_ff <= src_data;
          wait_ff    <= wait_dec;
        end
        LCJ_WAIT: begin
          // one extra pass here when the destination is a port
          wait_ff    <= wait_dec;
          done_ff    <= wait_last;
        end
        default: ;
      endcase
    end
  end

  // every output is a register, so the core never sees decode glitches
  assign wr_en         = wr_en_ff;
  assign wr_addr       = wr_addr_ff;
  assign wr_data       = wr_data_ff;
  assign rd_addr       = rd_addr_ff;
  assign pc_load       = pc_load_ff;
  assign pc_out        = pc_ff;
  assign stack_pointer = sp_ff;
  assign busy          = busy_ff;
  assign done          = done_ff;
  assign illegal       = ill_ff;
endmodule : lcj_exec

/* tb/lcj_mem_model.sv */
// partner: memory word behind the read address
`timescale 1ns/100ps
module lcj_mem_model (
  // read port
  input  wire logic [15:0] rd_addr,
  output logic      [15:0] mem_word
);
  // scrambled so a stale address never reads back plausibly
  assign mem_word = {rd_addr[7:0] ^ 8'h3C, rd_addr[15:8] ^ 8'hC3};
endmodule : lcj_mem_model

/* tb/lcj_exec_asserts.sv */
// checker: port assertions for the executor
`timescale 1ns/100ps
module lcj_exec_asserts (
  // inputs
  input wire logic clk, reset_n, instr_valid, source_mode,
  input wire logic [7:0] instr_byte, opnd_a, opnd_b, stack_pointer_in, src_data, wr_data,
  input wire logic [15:0] pc_in, wr_addr, pc_out,
  // results
  input wire logic wr_en, pc_load, busy, done, illegal
);
  import lcj_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic        esc_ff;
  logic [15:0] ret;
  logic [7:0]  sp1;
  wire take = instr_valid && !busy;
  wire mv   = take && (instr_byte == OP_MOV_D8_D8 || instr_byte == OP_MOV_D8_A);
  wire port = opnd_a[7:6] == 2'b10 && opnd_a[3:0] == 4'h0;
  wire [15:0] w = {wr_addr[7:0], wr_data};
  assign ret = pc_in + CALL_ADVANCE;
  assign sp1 = stack_pointer_in + SP_STEP;
  wire [15:0] lo_w = {sp1, ret[7:0]};
  wire [15:0] hi_w = {sp1 + SP_STEP, ret[15:8]};
  wire [15:0] mv_w = {opnd_a, src_data};
  // an escape on the previous edge exempts the register move
  always_ff @(posedge clk) esc_ff <= reset_n && instr_valid && instr_byte == ESC_PREFIX;
  a_call_low: assert property (take && instr_byte == OP_CALL_IND
    |-> ##2 wr_en && w == $past(lo_w, 2)) else $error("call low push wrong");
  a_call_high: assert property (take && instr_byte == OP_CALL_IND
    |-> ##3 wr_en && w == $past(hi_w, 3) ##1 pc_load && done) else $error("call high push wrong");
  a_jmp_abs: assert property (take && instr_byte == OP_JMP_ABS
    |=> pc_load && pc_out == {$past(opnd_a), $past(opnd_b)}) else $error("jump target wrong");
  a_move_copy: assert property (mv |-> ##2 wr_en && w == $past(mv_w, 2) ##1 !wr_en)
    else $error("move write wrong");
  a_move_base: assert property (mv && !port |-> ##1 !done [*2] ##1 done)
    else $error("move time wrong");
  a_port_extra: assert property (mv && port |-> ##1 !done [*3] ##1 done)
    else $error("port move time wrong");
  a_src_escape: assert property (take && source_mode && instr_byte == OP_MOV_D8_RN
    && !esc_ff |=> illegal) else $error("missing refusal");
  cover property (take && instr_byte == OP_CALL_IND);
  cover property (take && instr_byte == OP_JMP_ABS);
  cover property (mv && port);
  cover property (illegal);
endmodule : lcj_exec_asserts
bind lcj_exec lcj_exec_asserts u_chk (.*);

/* tb/tb_top.sv */
// testbench: calls, jumps and moves with queued expectations
`timescale 1ns/100ps
module tb_top;
  import lcj_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, source_mode = 1'b0;
  logic [7:0]  instr_byte = 8'h00, opnd_a = 8'h00, opnd_b = 8'h00, src_data = 8'h00;
  logic [7:0]  stack_pointer_in = 8'h00, wr_data, stack_pointer, a;
  logic [15:0] pc_in = 16'h0000, word_register_data = 16'h0000, mem_word, wr_addr, rd_addr;
  logic [15:0] pc_out, ret, lat_mv, exp_w[$], exp_p[$];
  logic        wr_en, pc_load, busy, done, illegal;
  logic [31:0] seed = 32'hB406EAE4;
  int          n_mismatch = 0, cmp_count = 0, cyc = 0;
  lcj_exec      uut (.*);
  lcj_mem_model u_mem (.*);
  always #10 clk = ~clk;
  function automatic logic [15:0] memf(input logic [15:0] x);
    return {x[7:0] ^ 8'h3C, x[15:8] ^ 8'hC3};
  endfunction : memf
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic run(input logic esc, input logic [7:0] op, input logic [15:0] lat, input logic ill);
    logic [15:0] n;
    n = 16'h0000;
    instr_valid = 1'b1;
    instr_byte = esc ? ESC_PREFIX : op;
    if (esc) begin
      @(posedge clk);
      #1 instr_byte = op;
    end
    @(posedge clk);
    #1 instr_valid = 1'b0;
    while (done !== 1'b1 && illegal !== 1'b1 && n < 16'h0010) begin
      @(posedge clk);
      #1 n++;
    end
    chk({15'h0000, illegal}, {15'h0000, ill});
    if (!ill) chk(n, lat);
    chk({15'h0000, busy}, 16'h0000);
  endtask : run
  // results land one edge after the design registers them
  always @(posedge clk) begin
    if (wr_en === 1'b1) chk(w_seen(), exp_w.size() ? exp_w.pop_front() : 16'hX);
    if (pc_load === 1'b1) chk(pc_out, exp_p.size() ? exp_p.pop_front() : 16'hX);
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      final_report();
    end
  end
  function automatic logic [15:0] w_seen();
    return {wr_addr[7:0], wr_data};
  endfunction : w_seen
  initial begin
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    pc_in = $random(seed);
    stack_pointer_in = $random(seed);
    word_register_data = $random(seed);
    ret = pc_in + CALL_ADVANCE;
    exp_w.push_back({stack_pointer_in + SP_STEP, ret[7:0]});
    exp_w.push_back({stack_pointer_in + 8'h02, ret[15:8]});
    exp_p.push_back(memf(word_register_data));
    run(1'b0, OP_CALL_IND, 16'h0003, 1'b0);
    chk({8'h00, stack_pointer}, {8'h00, stack_pointer_in + 8'h02});
    chk(rd_addr, word_register_data);
    opnd_a = $random(seed);
    opnd_b = $random(seed);
    exp_p.push_back({opnd_a, opnd_b});
    run(1'b0, OP_JMP_ABS, 16'h0000, 1'b0);
    // fresh pointer, so a target read from a stale address shows up
    word_register_data = $random(seed);
    exp_p.push_back(memf(word_register_data));
    // binary mode: the indirect jump lives behind the escape
    run(1'b1, OP_JMP_IND, 16'h0001, 1'b0);
    // every port address, then plain addresses
    for (int i = 0; i < 11; i++) begin
      a = $random(seed);
      a[7:6] = 2'b01;
      if (i < 4) a = {2'b10, i[1:0], 4'h0};
      opnd_a = a;
      src_data = $random(seed);
      source_mode = (i > 8);
      if (i != 9) exp_w.push_back({a, src_data});
      lat_mv = 16'(BASE_STATES) + ((i < 4) ? 16'(PORT_EXTRA) : 16'h0000);
      if (i < 8) run(1'b0, i[0] ? OP_MOV_D8_A : OP_MOV_D8_D8, lat_mv, 1'b0);
      else run(i == 10, OP_MOV_D8_RN, lat_mv, i == 9);
    end
    chk(16'(exp_w.size() + exp_p.size()), 16'h0000);
    final_report();
  end
endmodule : tb_top
